// ### pcb_cfg_header.sv
// configuration header slice 18h..34h plus the header write unlock at 40h
// ==========================================================
// Notes on behaviour
// - task-file-base bits 31:3 store written address
// - bits 2:0 read fixed 001
// - control base bits 31:2 writable
// - control base bits 1:0 read 01
// - bus master base bits 31:4 writable
// - bus master base bits 3:0 read 0001
// - memory base enabled only by strap high
// - memory base bits 31:8 writable when enabled
// - memory base bits 7:0 read zero
// - identity: product 31:16, vendor 15:0, writable only under unlock
// - identity from default, external load, or write
// - eeprom valid when both words read 55aa
// - flash valid with aa55 and 55 signatures
// - identity writable only when unlock bit set
// - option rom base bits 31:19 writable
// - option rom bits 18:1 read zero
// - rom decode only while enable bit set
// - capability pointer reads 60 hex
// - capability pointer bits 31:8 read zero
// - unlock bit 0 at 40h opens identity writes
`default_nettype none
module pcb_cfg_header #(
  parameter logic [31:0] DEFAULT_ID = 32'h1234_abcd  // arbitrary neutral identity
) (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // configuration access port, same clock domain
  input  wire logic        cfg_wr_i,       // one cycle write strobe
  input  wire logic        cfg_rd_i,       // one cycle read strobe
  input  wire logic [7:0]  cfg_addr_i,     // byte offset, dword aligned
  input  wire logic [3:0]  cfg_be_i,       // byte enables
  input  wire logic [31:0] cfg_wdata_i,    // write data
  output logic [31:0]      cfg_rdata_o,    // read data, valid with cfg_ack_o
  output logic             cfg_ack_o,      // one cycle answer
  // strap pin
  input  wire logic        memory_bar_strap_enable_i,
  // external memory reader
  output logic             ext_rd_req_o,
  output logic             ext_rd_flash_o,
  output logic [18:0]      ext_rd_addr_o,
  input  wire logic        ext_rd_ack_i,
  input  wire logic [31:0] ext_rd_data_i,
  // decode state for the rest of the device
  output logic [31:0]      task1_base_o,
  output logic [31:0]      cmd1_base_o,
  output logic [31:0]      bm_base_o,
  output logic [31:0]      mem_base_o,
  output logic             mem_bar_en_o,   // memory window usable
  output logic [31:0]      rom_base_o,
  output logic             rom_decode_en_o,
  output logic [31:0]      subsys_id_o,
  output logic             id_ready_o      // identity source settled
);
  import pcb_pkg::*;

  // ==========================================================
  // storage
  logic [31:0] task1_q;    // channel 1 task file base, writable bits only
  logic [31:0] cmd1_q;     // channel 1 control block base
  logic [31:0] bm_q;       // bus master base
  logic [31:0] mem_q;      // driver memory base
  logic [31:0] rom_q;      // option rom base with enable in bit 0
  logic [31:0] id_q;       // subsystem identity
  logic        unlock_q;   // header write unlock
  logic        strap_s;    // synchronised strap
  logic        ld_load;    // loader result strobe
  logic [31:0] ld_id;      // loader result
  logic        ld_done;    // loader finished
  logic [31:0] rdata_d;    // read mux
  logic [31:0] bemask;     // byte enable mask

  // merge written bytes into a register under a writable mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] be, input logic [31:0] wm);
    merge = (old & ~(be & wm)) | (wd & be & wm);
  endfunction

  assign bemask = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};

  // ==========================================================
  // strap input from a pin
  pcb_sync u_strap (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .d_i       (memory_bar_strap_enable_i),
    .q_o       (strap_s)
  );

  // ==========================================================
  // identity loader
  pcb_id_loader u_loader (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .rd_req_o   (ext_rd_req_o),
    .rd_flash_o (ext_rd_flash_o),
    .rd_addr_o  (ext_rd_addr_o),
    .rd_ack_i   (ext_rd_ack_i),
    .rd_data_i  (ext_rd_data_i),
    .load_o     (ld_load),
    .id_o       (ld_id),
    .done_o     (ld_done)
  );

  // ==========================================================
  // i/o base registers; only writable bits are held, so an all-ones
  // write reads back as the window size mask plus fixed bits
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      task1_q <= BAR_RESET;
      cmd1_q  <= BAR_RESET;
      bm_q    <= BAR_RESET;
    end else if (cfg_wr_i) begin
      if (cfg_addr_i == OFF_TASK1) task1_q <= merge(task1_q, cfg_wdata_i, bemask, MASK_TASK);
      if (cfg_addr_i == OFF_CMD1)  cmd1_q  <= merge(cmd1_q, cfg_wdata_i, bemask, MASK_CMD);
      if (cfg_addr_i == OFF_BM)    bm_q    <= merge(bm_q, cfg_wdata_i, bemask, MASK_BM);
    end
  end

  // ==========================================================
  // memory base: writes dropped while the strap is low
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_q <= BAR_RESET;
    end else if (!strap_s) begin
      mem_q <= BAR_RESET;
    end else if (cfg_wr_i && cfg_addr_i == OFF_MEM) begin
      mem_q <= merge(mem_q, cfg_wdata_i, bemask, MASK_MEM);
    end
  end

  // ==========================================================
  // option rom base with its enable bit
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rom_q <= BAR_RESET;
    end else if (cfg_wr_i && cfg_addr_i == OFF_ROM) begin
      rom_q <= merge(rom_q, cfg_wdata_i, bemask, MASK_ROM);
    end
  end

  // ==========================================================
  // header write unlock, bit 0 at 40h
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      unlock_q <= 1'b0;
    end else if (cfg_wr_i && cfg_addr_i == OFF_CFGCTL && cfg_be_i[0]) begin
      unlock_q <= cfg_wdata_i[0];
    end
  end

  // ==========================================================
  // subsystem identity: default, then loader, then unlocked writes
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      id_q <= 32'h0;
    end else if (!ld_done && !ld_load) begin
      id_q <= DEFAULT_ID;
    end else if (ld_load) begin
      id_q <= ld_id;
    end else if (cfg_wr_i && cfg_addr_i == OFF_SUBSYS && unlock_q) begin
      id_q <= merge(id_q, cfg_wdata_i, bemask, 32'hffff_ffff);
    end
  end

  // ==========================================================
  // read mux with fixed low bits; unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0;
    unique case (cfg_addr_i)
      OFF_TASK1:  rdata_d = (task1_q & MASK_TASK) | FIX_TASK;
      OFF_CMD1:   rdata_d = (cmd1_q & MASK_CMD) | FIX_CMD;
      OFF_BM:     rdata_d = (bm_q & MASK_BM) | FIX_BM;
      OFF_MEM:    rdata_d = mem_q & MASK_MEM;
      OFF_SUBSYS: rdata_d = id_q;
      OFF_ROM:    rdata_d = rom_q & MASK_ROM;
      OFF_CAP:    rdata_d = CAP_VALUE;
      OFF_CFGCTL: rdata_d = {31'h0, unlock_q};
      default:    rdata_d = 32'h0;
    endcase
  end

  // ==========================================================
  // registered answer, one cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_rdata_o <= 32'h0;
      cfg_ack_o   <= 1'b0;
    end else begin
      cfg_ack_o   <= cfg_rd_i | cfg_wr_i;
      cfg_rdata_o <= cfg_rd_i ? rdata_d : 32'h0;
    end
  end

  // ==========================================================
  // decode outputs, registered
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      task1_base_o    <= 32'h0;
      cmd1_base_o     <= 32'h0;
      bm_base_o       <= 32'h0;
      mem_base_o      <= 32'h0;
      mem_bar_en_o    <= 1'b0;
      rom_base_o      <= 32'h0;
      rom_decode_en_o <= 1'b0;
      subsys_id_o     <= 32'h0;
      id_ready_o      <= 1'b0;
    end else begin
      task1_base_o    <= task1_q & MASK_TASK;
      cmd1_base_o     <= cmd1_q & MASK_CMD;
      bm_base_o       <= bm_q & MASK_BM;
      mem_base_o      <= mem_q & MASK_MEM;
      mem_bar_en_o    <= strap_s;
      rom_base_o      <= rom_q & MASK_ROM;
      rom_decode_en_o <= rom_q[0];
      subsys_id_o     <= id_q;
      id_ready_o      <= ld_done;
    end
  end
endmodule
`default_nettype wire

// ### pcb_pkg.sv
// constants shared by the configuration header slice
`default_nettype none
package pcb_pkg;
  // ==========================================================
  // register offsets (byte addresses in configuration space)
  localparam logic [7:0] OFF_TASK1    = 8'h18;  // channel 1 task file base
  localparam logic [7:0] OFF_CMD1     = 8'h1c;  // channel 1 control block base
  localparam logic [7:0] OFF_BM       = 8'h20;  // bus master base
  localparam logic [7:0] OFF_MEM      = 8'h24;  // driver memory base
  localparam logic [7:0] OFF_SUBSYS   = 8'h2c;  // subsystem identity
  localparam logic [7:0] OFF_ROM      = 8'h30;  // option rom base
  localparam logic [7:0] OFF_CAP      = 8'h34;  // capability pointer
  localparam logic [7:0] OFF_CFGCTL   = 8'h40;  // configuration control
  // ==========================================================
  // writable masks and hardwired low bits
  localparam logic [31:0] MASK_TASK   = 32'hffff_fff8;
  localparam logic [31:0] FIX_TASK    = 32'h0000_0001;
  localparam logic [31:0] MASK_CMD    = 32'hffff_fffc;
  localparam logic [31:0] FIX_CMD     = 32'h0000_0001;
  localparam logic [31:0] MASK_BM     = 32'hffff_fff0;
  localparam logic [31:0] FIX_BM      = 32'h0000_0001;
  localparam logic [31:0] MASK_MEM    = 32'hffff_ff00;
  localparam logic [31:0] MASK_ROM    = 32'hfff8_0001;
  localparam logic [31:0] CAP_VALUE   = 32'h0000_0060;
  localparam logic [31:0] BAR_RESET   = 32'h0000_0000;
  // ==========================================================
  // identity load signatures
  localparam logic [15:0] EE_SIG     = 16'h55aa;
  localparam logic [15:0] FL_SIG_HI  = 16'haa55;
  localparam logic [7:0]  FL_SIG_LO  = 8'h55;
  localparam logic [18:0] FL_ADDR_HI = 19'h7fffe;
  localparam logic [18:0] FL_ADDR_LO = 19'h7fffc;
  // ==========================================================
  // loader states
  typedef enum logic [2:0] {
    LD_IDLE = 3'b000,
    LD_EE   = 3'b001,
    LD_FL1  = 3'b010,
    LD_FL2  = 3'b011,
    LD_DONE = 3'b100
  } pcb_ld_e;
endpackage
`default_nettype wire

// ### pcb_sync.sv
// two flop synchroniser for a level from a pin
`default_nettype none
module pcb_sync (
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;  // first stage, read only by the second
  // ==========================================================
  // two stages
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### pcb_id_loader.sv
// identity loader: fetches signatures and the identity word after reset
`default_nettype none
module pcb_id_loader (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  output logic             rd_req_o,    // read request to external memory
  output logic             rd_flash_o,  // 1: flash, 0: serial eeprom
  output logic [18:0]      rd_addr_o,   // byte address of the word
  input  wire logic        rd_ack_i,    // read done, data valid
  input  wire logic [31:0] rd_data_i,   // read data
  output logic             load_o,      // one cycle: identity valid
  output logic [31:0]      id_o,        // identity loaded
  output logic             done_o       // loading sequence finished
);
  import pcb_pkg::*;
  pcb_ld_e st_q;  // sequence state
  // ==========================================================
  // sequence: eeprom words 0..3, then flash signature, then give up
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q      <= LD_IDLE;
      rd_req_o  <= 1'b0;
      rd_flash_o <= 1'b0;
      rd_addr_o <= 19'h0;
      load_o    <= 1'b0;
      id_o      <= 32'h0;
      done_o    <= 1'b0;
    end else begin
      load_o <= 1'b0;
      unique case (st_q)
        LD_IDLE: begin
          rd_req_o  <= 1'b1;   // eeprom words 03:02 and 01:00 at once
          rd_flash_o <= 1'b0;
          rd_addr_o <= 19'h0;
          st_q      <= LD_EE;
        end
        LD_EE: if (rd_ack_i) begin
          // both halves must carry the signature
          if (rd_data_i == {EE_SIG, EE_SIG}) begin
            rd_addr_o <= 19'h4;  // identity follows the signature
            st_q      <= LD_FL2;
          end else begin
            rd_flash_o <= 1'b1;
            rd_addr_o <= FL_ADDR_HI;
            st_q      <= LD_FL1;
          end
        end
        LD_FL1: if (rd_ack_i) begin
          // hi half at 7fffe, lo byte reports 7fffc
          if (rd_data_i[31:16] == FL_SIG_HI && rd_data_i[7:0] == FL_SIG_LO) begin
            rd_addr_o <= FL_ADDR_LO - 19'h4;
            st_q      <= LD_FL2;
          end else begin
            rd_req_o <= 1'b0;  // no source, defaults stand
            st_q     <= LD_DONE;
          end
        end
        LD_FL2: if (rd_ack_i) begin
          id_o     <= rd_data_i;
          load_o   <= 1'b1;
          rd_req_o <= 1'b0;
          st_q     <= LD_DONE;
        end
        LD_DONE: begin
          rd_req_o <= 1'b0;
          done_o   <= 1'b1;
        end
        default: st_q <= LD_DONE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### pcb_ext_mem_model.sv
// behavioural external identity memory answering the loader
`default_nettype none
module pcb_ext_mem_model #(
  parameter logic [31:0] ID_EE = 32'h5a5a_0101,  // arbitrary identity in eeprom
  parameter logic [31:0] ID_FL = 32'h3c3c_0202   // arbitrary identity in flash
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rd_req_i,
  input  wire logic        rd_flash_i,
  input  wire logic [18:0] rd_addr_i,
  input  wire logic [1:0]  mode_i,     // 0 eeprom, 1 flash, else blank
  input  wire logic [3:0]  wait_i,     // answer latency in cycles
  output logic             rd_ack_o,
  output logic [31:0]      rd_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial rd_ack_o = 1'b0;
  initial rd_data_o = 32'h0;
  // ==========
  // contents: a blank part reads all ones
  function automatic logic [31:0] word(input logic f, input logic [18:0] a);
    if (!f && mode_i == 2'd0) return (a == 19'h0) ? 32'h55aa_55aa : ID_EE;
    if (f && mode_i == 2'd1) return (a == 19'h7fffe) ? 32'haa55_0055 : ID_FL;
    return 32'hffff_ffff;
  endfunction
  // ==========
  // answer after wait_i cycles; data toggles when not valid so stale values never pass
  always @(posedge sys_clk_i) begin
    rd_ack_o <= 1'b0;
    rd_data_o <= ~rd_data_o;
    if (!rd_req_i || rd_ack_o) cnt <= 0;
    else if (cnt == wait_i) begin
      rd_ack_o <= 1'b1;
      rd_data_o <= word(rd_flash_i, rd_addr_i);
    end else cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

// ### pcb_cfg_header_chk.sv
// checker for the configuration header slice
`default_nettype none
module pcb_cfg_header_chk (
  input wire logic        sys_clk_i,
  input wire logic        resetn_i,
  input wire logic        cfg_rd_i,
  input wire logic [7:0]  cfg_addr_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        memory_bar_strap_enable_i,
  input wire logic        mem_bar_en_o,
  input wire logic [31:0] mem_base_o,
  input wire logic        rom_decode_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========
  // hardwired bits on read
  chk_task_low_bits: assert property (
    cfg_rd_i && cfg_addr_i == 8'h18 |=> cfg_rdata_o[2:0] == 3'b001) else $error("task low bits");
  chk_ctl_low_bits: assert property (
    cfg_rd_i && cfg_addr_i == 8'h1c |=> cfg_rdata_o[1:0] == 2'b01) else $error("ctl low bits");
  chk_bm_low_bits: assert property (
    cfg_rd_i && cfg_addr_i == 8'h20 |=> cfg_rdata_o[3:0] == 4'h1) else $error("bm low bits");
  chk_mem_low_bits: assert property (
    cfg_rd_i && cfg_addr_i == 8'h24 |=> cfg_rdata_o[7:0] == 8'h00) else $error("mem low bits");
  chk_rom_mid_bits: assert property (
    cfg_rd_i && cfg_addr_i == 8'h30 |=> cfg_rdata_o[18:1] == 18'h0) else $error("rom bits");
  chk_cap_value: assert property (
    cfg_rd_i && cfg_addr_i == 8'h34 |=> cfg_rdata_o == 32'h60) else $error("cap value");
  // ==========
  // strap and reset effects
  chk_strap_off: assert property (
    !memory_bar_strap_enable_i [*4] |=> !mem_bar_en_o && mem_base_o == 32'h0)
    else $error("memory window open with strap low");
  chk_reset_clear: assert property (
    $rose(resetn_i) |-> mem_base_o == 32'h0 && !rom_decode_en_o) else $error("reset clear");
endmodule
`default_nettype wire

// ### pcb_cfg_header_tb.sv
// self-checking bench for the configuration header slice
`default_nettype none
module pcb_cfg_header_tb;
  import pcb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] DEF_ID = 32'h0bad_cafe;  // arbitrary
  localparam logic [31:0] ID_EE  = 32'h5a5a_0101;  // arbitrary
  localparam logic [31:0] ID_FL  = 32'h3c3c_0202;  // arbitrary
  localparam logic [7:0]  OFFS [8] = '{OFF_TASK1, OFF_CMD1, OFF_BM, OFF_MEM, OFF_ROM, OFF_CAP,
                                       OFF_CFGCTL, 8'h08};
  localparam logic [31:0] RSTV [8] = '{1, 1, 1, 0, 0, 32'h60, 0, 0};
  localparam logic [31:0] SIZV [8] = '{32'hffff_fff9, 32'hffff_fffd, 32'hffff_fff1,
                                       32'hffff_ff00, 32'hfff8_0001, 32'h60, 1, 0};
  logic        sys_clk_i = 0, resetn_i = 0, wr = 0, rd = 0, strap = 1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, id, xdata;
  logic [31:0] t1b, c1b, bmb, memb, romb;
  logic        ack, bar_en, rom_en, ready, req, fl, xack;
  logic [18:0] xaddr;
  logic [1:0]  mode = 2'd0;
  logic [3:0]  lat = 4'd0;
  int          err_total = 0, check_count = 0;
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  pcb_cfg_header #(.DEFAULT_ID(DEF_ID)) dut (.sys_clk_i, .resetn_i, .cfg_wr_i(wr), .cfg_rd_i(rd),
    .cfg_addr_i(addr), .cfg_be_i(4'hf), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
    .memory_bar_strap_enable_i(strap), .ext_rd_req_o(req), .ext_rd_flash_o(fl),
    .ext_rd_addr_o(xaddr), .ext_rd_ack_i(xack), .ext_rd_data_i(xdata), .task1_base_o(t1b),
    .cmd1_base_o(c1b), .bm_base_o(bmb), .mem_base_o(memb), .mem_bar_en_o(bar_en),
    .rom_base_o(romb),
    .rom_decode_en_o(rom_en), .subsys_id_o(id), .id_ready_o(ready));
  pcb_ext_mem_model #(.ID_EE(ID_EE), .ID_FL(ID_FL)) u_mem (.sys_clk_i, .rd_req_i(req),
    .rd_flash_i(fl), .rd_addr_i(xaddr), .mode_i(mode), .wait_i(lat), .rd_ack_o(xack),
    .rd_data_o(xdata));
  // ==========
  // access and compare tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // strobe for one cycle, answer stands in the following cycle
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i) #1;
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(posedge sys_clk_i) #1;
    wr = 0;
    rd = 0;
    chk("ack", 1, {31'h0, ack});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    access(0, a, 32'h0);
    chk($sformatf("reg %h", a), exp, rdata);
  endtask
  // reset with a chosen memory content, then wait for the loader
  task automatic boot(input logic [1:0] m, input logic [3:0] l);
    resetn_i = 0;
    mode = m;
    lat = l;
    repeat (3) @(posedge sys_clk_i);
    #1 resetn_i = 1;
    for (int i = 0; i < 300 && ready !== 1'b1; i++) begin
      @(posedge sys_clk_i) #1;
    end
    chk("ready", 1, {31'h0, ready});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========
  // watchdog: about 140 cycles are expected, allow far more
  initial begin
    #100us;
    err_total++;
    results();
  end
  // ==========
  // test sequence
  initial begin
    boot(2'd0, 4'd0);
    rdc(OFF_SUBSYS, ID_EE);
    for (int i = 0; i < 8; i++) rdc(OFFS[i], RSTV[i]);
    access(1, OFF_SUBSYS, 32'hdead_beef);
    rdc(OFF_SUBSYS, ID_EE);
    for (int i = 0; i < 8; i++) access(1, OFFS[i], 32'hffff_ffff);
    for (int i = 0; i < 8; i++) rdc(OFFS[i], SIZV[i]);
    chk("rom_en", 1, {31'h0, rom_en});
    chk("bar_en", 1, {31'h0, bar_en});
    chk("task1_base", 32'hffff_fff8, t1b);
    chk("cmd1_base", 32'hffff_fffc, c1b);
    chk("bm_base", 32'hffff_fff0, bmb);
    chk("mem_base", 32'hffff_ff00, memb);
    chk("rom_base", 32'hfff8_0001, romb);
    access(1, OFF_SUBSYS, 32'hdead_beef);
    rdc(OFF_SUBSYS, 32'hdead_beef);
    chk("id", 32'hdead_beef, id);
    access(1, OFF_TASK1, 32'h1234_5678);
    rdc(OFF_TASK1, 32'h1234_5679);
    access(1, OFF_CMD1, 32'hcafe_f00e);
    rdc(OFF_CMD1, 32'hcafe_f00d);
    access(1, OFF_BM, 32'h0000_a5aa);
    rdc(OFF_BM, 32'h0000_a5a1);
    access(1, OFF_MEM, 32'h8765_43ff);
    rdc(OFF_MEM, 32'h8765_4300);
    access(1, OFF_ROM, 32'h0008_0000);
    rdc(OFF_ROM, 32'h0008_0000);
    chk("rom_en", 0, {31'h0, rom_en});
    strap = 0;
    repeat (5) @(posedge sys_clk_i);
    rdc(OFF_MEM, 32'h0);
    access(1, OFF_MEM, 32'hffff_ffff);
    rdc(OFF_MEM, 32'h0);
    chk("bar_en", 0, {31'h0, bar_en});
    strap = 1;
    boot(2'd1, 4'd5);
    rdc(OFF_SUBSYS, ID_FL);
    rdc(OFF_ROM, 32'h0);
    boot(2'd2, 4'd0);
    rdc(OFF_SUBSYS, DEF_ID);
    results();
  end
endmodule
bind pcb_cfg_header pcb_cfg_header_chk u_chk (.sys_clk_i, .resetn_i, .cfg_rd_i, .cfg_addr_i,
  .cfg_rdata_o, .memory_bar_strap_enable_i, .mem_bar_en_o, .mem_base_o, .rom_decode_en_o);
`default_nettype wire
